// ===== design/mpm_monitor.sv
// Functional notes
// - compare encoder frequency against ramp output every cycle.
// - speed error latches slip compensation off until setting rewritten.
// - speed error response 0 none, 1 warning, 2 coasting fault.
// - threshold applies to absolute speed difference, percent of nominal.
// - speed fault only after difference persists for the delay time.
// - thermal response fires at 105 percent; 0 none,1 warn,2 fault,3 coast.
// - thermal load from output current; limit depends on output frequency.
// - time constant 1 to 200 minutes; 63 percent reached in one constant.
// - stopped drive uses three times the configured time constant.
// - ambient factor -100..100 percent maps to 0, 40, 80 degrees.
// - zero-speed cooling is percent of motor current, output limit untouched.
// - duty setting 0..150 percent scales the nominal current point.
// - thermistor response 0 disabled,1 warn,2 fault,3 coast fault.
// - overload input select 0 off,1 current,2 torque,3 power.
// - every 100 ms counter rises above 105 percent, falls below.
// - overload trips when counter exceeds 10000.
// - increment linear from zero at 105 percent to full step at level.
// - overload response 0 none, 1 warning, 2 fault.
`timescale 1ns/10ps
`default_nettype none
module mpm_monitor
	import mpm_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
)
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	input  wire logic        ce_i,
	// register port
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	// drive measurements, 0.1 % units
	input  wire logic [15:0] ramp_freq_i,
	input  wire logic [15:0] enc_freq_i,
	input  wire logic [15:0] out_current_i,
	input  wire logic [15:0] motor_torque_i,
	input  wire logic [15:0] motor_power_i,
	input  wire logic        running_i,
	input  wire logic        thermistor_trip_i,
	// responses
	output logic             slip_comp_en_o,
	output logic             warning_o,
	output logic             fault_o,
	output logic             coast_stop_o
);

	// configuration registers
	logic [1:0]  spd_resp_reg;
	logic [15:0] spd_limit_reg;
	logic [15:0] spd_delay_reg;
	logic [1:0]  th_resp_reg;
	logic [1:0]  tf_resp_reg;
	logic [15:0] amb_reg;
	logic [15:0] cool_reg;
	logic [7:0]  tc_reg;
	logic [15:0] duty_reg;
	logic [1:0]  ovl_resp_reg;
	logic [1:0]  ovl_sel_reg;
	logic [15:0] ovl_level_reg;
	logic [15:0] ovl_step_reg;
	// state
	logic        slip_off_reg;
	logic        slip_en_reg;
	logic [15:0] spd_cnt_reg;
	logic        spd_err_reg;
	logic [31:0] tick_cnt_reg;
	logic        tick_reg;
	logic [31:0] theta_reg;
	logic [31:0] ovl_cnt_reg;
	logic [31:0] rdata_reg;
	logic        warn_reg;
	logic        fault_reg;
	logic        coast_reg;

	function automatic logic [1:0] resp_warn(input logic [1:0] r, input logic ev);
		resp_warn = (ev && r == MPM_RESP_WARN) ? 2'h1 : 2'h0;
	endfunction : resp_warn

	// write decode
	wire wr_ctrl  = ce_i && wr_i && addr_i == MPM_ADDR_CTRL;
	wire wr_spd   = ce_i && wr_i && addr_i == MPM_ADDR_SPD;
	wire wr_th    = ce_i && wr_i && addr_i == MPM_ADDR_THERM;
	wire wr_th2   = ce_i && wr_i && addr_i == MPM_ADDR_THERM2;
	wire wr_ovl   = ce_i && wr_i && addr_i == MPM_ADDR_OVL;

	wire [15:0] spd_diff = (ramp_freq_i > enc_freq_i) ? ramp_freq_i - enc_freq_i
	                                                   : enc_freq_i - ramp_freq_i;
	wire        spd_over = spd_diff > spd_limit_reg;
	// persistence for the delay, counted in ticks
	wire        spd_done = spd_over && spd_cnt_reg >= spd_delay_reg;

	// thermal current limit from frequency, cooling at zero speed
	wire [31:0] f_clip   = (ramp_freq_i > MPM_PCT_100) ? {16'h0, MPM_PCT_100}
	                                                    : {16'h0, ramp_freq_i};
	wire [31:0] cool_pt  = {16'h0, cool_reg} + (((MPM_PCT_100 - cool_reg) * f_clip)
	                       / MPM_PCT_100);
	// duty setting scales the nominal point
	wire [31:0] it_lim   = (cool_pt * duty_reg) / MPM_PCT_100;
	wire [15:0] thermal_current_limit = (it_lim == 32'h0) ? 16'h1 : it_lim[15:0];
	wire [31:0] ratio    = ({16'h0, out_current_i} << MPM_TH_FRAC) / thermal_current_limit;
	wire [63:0] ratio_sq = ({32'h0, ratio} * {32'h0, ratio}) >> MPM_TH_FRAC;
	// ambient offset, -100..100 % shifts target by up to half its value
	wire [31:0] amb_off  = {16'h0, amb_reg[14:0] & 15'h7fff, 1'b0} >> 1;
	wire [63:0] tgt_amb  = amb_reg[15] ? ratio_sq - (ratio_sq * amb_off[15:0]
	                       / {16'h0, MPM_AMB_MAX} / 2)
	                     : ratio_sq + (ratio_sq * amb_off[15:0] / {16'h0, MPM_AMB_MAX} / 2);
	wire [31:0] target   = (tgt_amb[63:32] != 32'h0) ? 32'hffffffff : tgt_amb[31:0];
	// tau in ticks; tripled when stopped
	wire [31:0] tau_tk   = {24'h0, tc_reg} * MPM_TICKS_PER_MIN
	                       * (running_i ? 32'h1 : {30'h0, MPM_STOP_TC_MUL});
	wire [31:0] th_delta = (target > theta_reg) ? (target - theta_reg) / tau_tk
	                                            : (theta_reg - target) / tau_tk;
	wire [31:0] th_next  = (target > theta_reg)
	                       ? theta_reg + ((th_delta == 0 && target != theta_reg) ? 32'h1 : th_delta)
	                       : theta_reg - ((th_delta == 0 && target != theta_reg) ? 32'h1 : th_delta);
	wire        th_hot   = theta_reg >= MPM_TH_TRIP;

	wire [15:0] ovl_in   = (ovl_sel_reg == MPM_OVL_CUR) ? out_current_i :
	                       (ovl_sel_reg == MPM_OVL_TRQ) ? motor_torque_i :
	                       (ovl_sel_reg == MPM_OVL_PWR) ? motor_power_i : 16'h0;
	wire        ovl_en   = ovl_sel_reg != MPM_OVL_OFF;
	wire [15:0] ovl_span = (ovl_level_reg > MPM_LEVEL_105) ? ovl_level_reg - MPM_LEVEL_105
	                                                       : 16'h1;
	wire        ovl_up   = ovl_in > MPM_LEVEL_105;
	wire [15:0] ovl_dist = ovl_up ? ovl_in - MPM_LEVEL_105 : MPM_LEVEL_105 - ovl_in;
	// linear step; same slope on shortfall
	wire [31:0] ovl_stp  = ({16'h0, ovl_dist} * {16'h0, ovl_step_reg}) / {16'h0, ovl_span};
	wire [31:0] ovl_nxt  = ovl_up ? ovl_cnt_reg + ovl_stp
	                     : (ovl_cnt_reg > ovl_stp) ? ovl_cnt_reg - ovl_stp : 32'h0;
	wire        ovl_trip = ovl_en && ovl_cnt_reg > MPM_OVL_TRIP;

	wire        tf_ev    = thermistor_trip_i && tf_resp_reg != MPM_RESP_NONE;
	wire        warn_nx  = resp_warn(spd_resp_reg, spd_done) != 2'h0
	                    || resp_warn(th_resp_reg, th_hot) != 2'h0
	                    || resp_warn(tf_resp_reg, tf_ev) != 2'h0
	                    || resp_warn(ovl_resp_reg, ovl_trip) != 2'h0;
	wire        coast_nx = (spd_done && spd_resp_reg == MPM_RESP_FAULT)
	                    || (th_hot && th_resp_reg == MPM_RESP_COAST)
	                    || (tf_ev && tf_resp_reg == MPM_RESP_COAST);
	wire        fault_nx = coast_nx
	                    || (th_hot && th_resp_reg == MPM_RESP_FAULT)
	                    || (tf_ev && tf_resp_reg == MPM_RESP_FAULT)
	                    || (ovl_trip && ovl_resp_reg == MPM_RESP_FAULT);

	// read mux
	wire [31:0] rd_mux =
		(addr_i == MPM_ADDR_CTRL)   ? {26'h0, tf_resp_reg, th_resp_reg, spd_resp_reg} :
		(addr_i == MPM_ADDR_SPD)    ? {spd_delay_reg, spd_limit_reg} :
		(addr_i == MPM_ADDR_THERM)  ? {amb_reg, cool_reg} :
		(addr_i == MPM_ADDR_THERM2) ? {8'h0, tc_reg, duty_reg} :
		(addr_i == MPM_ADDR_OVL)    ? {ovl_step_reg, ovl_level_reg[11:0], ovl_resp_reg,
		                               ovl_sel_reg} :
		(addr_i == MPM_ADDR_STATUS) ? {27'h0, spd_err_reg, slip_off_reg, coast_reg,
		                               fault_reg, warn_reg} :
		(addr_i == MPM_ADDR_TSTATE) ? theta_reg :
		(addr_i == MPM_ADDR_OCNT)   ? ovl_cnt_reg : 32'h0;

	// configuration registers
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			spd_resp_reg  <= MPM_RESP_NONE;
			th_resp_reg   <= MPM_RESP_NONE;
			tf_resp_reg   <= MPM_RESP_NONE;
			spd_limit_reg <= 16'h0;
			spd_delay_reg <= 16'h0;
			amb_reg       <= 16'h0;
			cool_reg      <= MPM_COOL_RST;
			tc_reg        <= MPM_TC_RST;
			duty_reg      <= MPM_DUTY_RST;
			ovl_resp_reg  <= MPM_RESP_NONE;
			ovl_sel_reg   <= MPM_OVL_OFF;
			ovl_level_reg <= MPM_LEVEL_105;
			ovl_step_reg  <= 16'h0;
		end
		else
		begin
			if (wr_ctrl)
			begin
				spd_resp_reg <= (wdata_i[1:0] == MPM_RESP_COAST) ? MPM_RESP_FAULT
				                                                 : wdata_i[1:0];
				th_resp_reg  <= wdata_i[3:2];
				tf_resp_reg  <= wdata_i[5:4];
			end
			if (wr_spd)
			begin
				spd_limit_reg <= wdata_i[15:0];
				spd_delay_reg <= wdata_i[31:16];
			end
			if (wr_th)
			begin
				cool_reg <= (wdata_i[15:0] > MPM_PCT_100) ? MPM_PCT_100 : wdata_i[15:0];
				// magnitude past twice full scale would drive the target below zero
				amb_reg  <= {wdata_i[31], (wdata_i[30:16] > MPM_AMB_MAX[14:0])
				             ? MPM_AMB_MAX[14:0] : wdata_i[30:16]};
			end
			if (wr_th2)
			begin
				duty_reg <= (wdata_i[15:0] > MPM_DUTY_MAX) ? MPM_DUTY_MAX : wdata_i[15:0];
				tc_reg   <= (wdata_i[23:16] < MPM_TC_MIN) ? MPM_TC_MIN :
				            (wdata_i[23:16] > MPM_TC_MAX) ? MPM_TC_MAX : wdata_i[23:16];
			end
			if (wr_ovl)
			begin
				ovl_sel_reg   <= wdata_i[1:0];
				ovl_resp_reg  <= (wdata_i[3:2] == MPM_RESP_COAST) ? MPM_RESP_FAULT
				                                                  : wdata_i[3:2];
				ovl_level_reg <= {4'h0, wdata_i[15:4]};
				ovl_step_reg  <= wdata_i[31:16];
			end
		end
	end

	// tick and monitors
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			tick_cnt_reg <= 32'h0;
			tick_reg     <= 1'b0;
			spd_cnt_reg  <= 16'h0;
			spd_err_reg  <= 1'b0;
			slip_off_reg <= 1'b0;
			slip_en_reg  <= 1'b1;
			theta_reg    <= 32'h0;
			ovl_cnt_reg  <= 32'h0;
		end
		else if (ce_i)
		begin
			tick_reg     <= tick_cnt_reg == 32'(TICK_LEN - 1);
			tick_cnt_reg <= (tick_cnt_reg == 32'(TICK_LEN - 1)) ? 32'h0 : tick_cnt_reg + 32'h1;
			// persistence counter, cleared when in tolerance
			if (!spd_over)
				spd_cnt_reg <= 16'h0;
			else if (tick_reg && !spd_done)
				spd_cnt_reg <= spd_cnt_reg + 16'h1;
			spd_err_reg <= spd_done;
			// detection wins over a rewrite in the same cycle
			if (spd_done)
			begin
				slip_off_reg <= 1'b1;
				slip_en_reg  <= 1'b0;
			end
			else if (wr_spd)
			begin
				slip_off_reg <= 1'b0;
				slip_en_reg  <= 1'b1;
			end
			if (tick_reg)
				theta_reg <= th_next;
			if (!ovl_en)
				ovl_cnt_reg <= 32'h0;
			else if (tick_reg)
				ovl_cnt_reg <= ovl_nxt;
		end
	end

	// outputs
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			rdata_reg <= 32'h0;
			warn_reg  <= 1'b0;
			fault_reg <= 1'b0;
			coast_reg <= 1'b0;
		end
		else if (ce_i)
		begin
			rdata_reg <= rd_i ? rd_mux : 32'h0;
			warn_reg  <= warn_nx;
			fault_reg <= fault_nx;
			coast_reg <= coast_nx;
		end
	end

	assign rdata_o        = rdata_reg;
	assign warning_o      = warn_reg;
	assign fault_o        = fault_reg;
	assign coast_stop_o   = coast_reg;
	assign slip_comp_en_o = slip_en_reg;

	a_slip_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!slip_comp_en_o && !wr_spd |=> !slip_comp_en_o)
		else $error("slip compensation re-enabled without rewrite");
	a_slip_off: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ce_i && spd_done |=> !slip_comp_en_o)
		else $error("slip compensation not disabled on speed error");
	a_spd_coast: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ce_i && spd_done && spd_resp_reg == MPM_RESP_FAULT |=> fault_o && coast_stop_o)
		else $error("speed error fault missing");
	// no speed error before the delay
	a_spd_delay: assert property (@(posedge clk_i) disable iff (!resetn_i)
		spd_err_reg |-> spd_cnt_reg >= spd_delay_reg || $past(spd_cnt_reg) >= spd_delay_reg)
		else $error("speed error before delay");
	a_th_warn: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ce_i && th_hot && th_resp_reg == MPM_RESP_WARN |=> warning_o)
		else $error("thermal warning missing");
	a_tf_off: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ce_i && tf_ev && tf_resp_reg == MPM_RESP_COAST |=> coast_stop_o)
		else $error("thermistor coast missing");
	a_ovl_trip: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ce_i && ovl_en && ovl_cnt_reg > MPM_OVL_TRIP && ovl_resp_reg == MPM_RESP_FAULT
		|=> fault_o)
		else $error("overload fault missing");
	a_ovl_floor: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ce_i && tick_reg && ovl_en && !ovl_up |=> ovl_cnt_reg <= $past(ovl_cnt_reg))
		else $error("overload counter rose below level");
	a_ovl_rise: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ce_i && tick_reg && ovl_en && ovl_up |=> ovl_cnt_reg >= $past(ovl_cnt_reg))
		else $error("overload counter fell above level");
	a_ovl_off: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ce_i && !ovl_en |=> ovl_cnt_reg == 32'h0)
		else $error("overload counter kept while deselected");
	// response 0 everywhere keeps warning, fault and coast outputs quiet
	a_resp_quiet: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ce_i && spd_resp_reg == MPM_RESP_NONE && th_resp_reg == MPM_RESP_NONE
		&& tf_resp_reg == MPM_RESP_NONE && ovl_resp_reg == MPM_RESP_NONE
		|=> !warning_o && !fault_o && !coast_stop_o)
		else $error("response raised with all selectors off");
	a_spd_warn: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ce_i && spd_done && spd_resp_reg == MPM_RESP_WARN |=> warning_o)
		else $error("speed error warning missing");
	a_ovl_warn: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ce_i && ovl_trip && ovl_resp_reg == MPM_RESP_WARN |=> warning_o)
		else $error("overload warning missing");
	a_tf_warn: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ce_i && thermistor_trip_i && tf_resp_reg == MPM_RESP_WARN |=> warning_o)
		else $error("thermistor warning missing");
	// time constant kept inside its range
	a_tc_range: assert property (@(posedge clk_i) disable iff (!resetn_i)
		tc_reg >= MPM_TC_MIN && tc_reg <= MPM_TC_MAX)
		else $error("time constant out of range");
	// difference seen, delay not yet elapsed
	sequence s_spd_short;
		ce_i && spd_over && spd_cnt_reg < spd_delay_reg;
	endsequence
	sequence s_spd_quiet;
		!spd_err_reg;
	endsequence
	a_spd_early: assert property (@(posedge clk_i) disable iff (!resetn_i)
		s_spd_short |=> s_spd_quiet)
		else $error("speed error flagged inside delay");
	// frozen clock enable holds all state
	a_ce_freeze: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!ce_i |=> $stable(theta_reg) && $stable(ovl_cnt_reg) && $stable(warning_o)
		&& $stable(slip_comp_en_o))
		else $error("state moved while clock enable low");

endmodule : mpm_monitor
`default_nettype wire

// ===== design/mpm_pkg.sv
package mpm_pkg;

	// register byte addresses (one word apart, byte address = index * 4)
	localparam logic [7:0] MPM_ADDR_CTRL   = 8'h00;
	localparam logic [7:0] MPM_ADDR_SPD    = 8'h04;
	localparam logic [7:0] MPM_ADDR_THERM  = 8'h08;
	localparam logic [7:0] MPM_ADDR_THERM2 = 8'h0c;
	localparam logic [7:0] MPM_ADDR_OVL    = 8'h10;
	localparam logic [7:0] MPM_ADDR_STATUS = 8'h14;
	localparam logic [7:0] MPM_ADDR_TSTATE = 8'h18;
	localparam logic [7:0] MPM_ADDR_OCNT   = 8'h1c;

	// response codes
	localparam logic [1:0] MPM_RESP_NONE  = 2'h0;
	localparam logic [1:0] MPM_RESP_WARN  = 2'h1;
	localparam logic [1:0] MPM_RESP_FAULT = 2'h2;
	localparam logic [1:0] MPM_RESP_COAST = 2'h3;

	// overload input select codes
	localparam logic [1:0] MPM_OVL_OFF    = 2'h0;
	localparam logic [1:0] MPM_OVL_CUR    = 2'h1;
	localparam logic [1:0] MPM_OVL_TRQ    = 2'h2;
	localparam logic [1:0] MPM_OVL_PWR    = 2'h3;

	// percent quantities in 0.1 % units, 16 bit; time constants in minutes, stop multiplier, overload trip count
	localparam logic [15:0] MPM_LEVEL_105    = 16'h041a;
	localparam logic [15:0] MPM_PCT_100      = 16'h03e8;
	localparam logic [15:0] MPM_AMB_MAX      = 16'h03e8;
	localparam logic [15:0] MPM_DUTY_MAX     = 16'h05dc;
	localparam logic [15:0] MPM_DUTY_RST     = 16'h03e8;
	localparam logic [7:0]  MPM_TC_MIN       = 8'h01;
	localparam logic [7:0]  MPM_TC_MAX       = 8'hc8;
	localparam logic [1:0]  MPM_STOP_TC_MUL  = 2'h3;
	localparam logic [31:0] MPM_OVL_TRIP     = 32'h00002710;
	localparam logic [15:0] MPM_COOL_RST     = 16'h0258;
	localparam logic [7:0]  MPM_TC_RST       = 8'h2d;

	// thermal state full scale: 16.16 fixed point, 1.0 = 100 %
	localparam int          MPM_TH_FRAC      = 16;
	localparam logic [31:0] MPM_TH_TRIP      = 32'h00010ccc;
	localparam int          MPM_TICKS_PER_MIN = 600;

	// timing
	localparam int TICK_MS       = 100;
	localparam int CLK_MHZ       = 250;
	localparam int TICK_CYCLES   = TICK_MS * 1000 * CLK_MHZ;

endpackage : mpm_pkg

// ===== dv/mpm_motor_model.sv
`timescale 1ns/10ps
`default_nettype none
module mpm_motor_model
(
	// commanded operating point
	input  wire logic [15:0] set_freq_i,
	input  wire logic [15:0] set_slip_i,
	input  wire logic [15:0] set_load_i,
	input  wire logic        set_run_i,
	input  wire logic        set_hot_i,
	// measurements toward the monitor
	output logic      [15:0] ramp_freq_o,
	output logic      [15:0] enc_freq_o,
	output logic      [15:0] current_o,
	output logic      [15:0] torque_o,
	output logic      [15:0] power_o,
	output logic             running_o,
	output logic             hot_o
);
	// slip wraps on purpose so a negative offset gives a slow encoder
	assign ramp_freq_o = set_freq_i;
	assign enc_freq_o  = set_freq_i + set_slip_i;
	// one load figure feeds all three overload sources
	assign current_o   = set_load_i;
	assign torque_o    = set_load_i;
	assign power_o     = set_load_i;
	assign running_o   = set_run_i;
	assign hot_o       = set_hot_i;
endmodule : mpm_motor_model
`default_nettype wire

// ===== dv/motor_protection_monitor_tb.sv
`timescale 1ns/10ps
`default_nettype none
module motor_protection_monitor_tb
	import mpm_pkg::*;
;
	localparam int TL = 100;
	logic        clk_i;
	logic        resetn_i;
	logic        ce_i;
	logic [7:0]  addr_i;
	logic [31:0] wdata_i;
	logic        wr_i;
	logic        rd_i;
	logic [31:0] rdata_o;
	logic [15:0] ramp, enc, cur, trq, pwr, set_freq, set_slip, set_load;
	logic        run, hot, set_run, set_hot, slip_en, warn, fault, coast;
	logic [31:0] a, b;
	int          fails, comparisons, i;

	mpm_motor_model motor (.set_freq_i(set_freq), .set_slip_i(set_slip), .set_load_i(set_load),
		.set_run_i(set_run), .set_hot_i(set_hot), .ramp_freq_o(ramp), .enc_freq_o(enc),
		.current_o(cur), .torque_o(trq), .power_o(pwr), .running_o(run), .hot_o(hot));

	mpm_monitor #(.TICK_LEN(TL)) uut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.ramp_freq_i(ramp), .enc_freq_i(enc), .out_current_i(cur), .motor_torque_i(trq),
		.motor_power_i(pwr), .running_i(run), .thermistor_trip_i(hot),
		.slip_comp_en_o(slip_en), .warning_o(warn), .fault_o(fault), .coast_stop_o(coast));

	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	task close_out;
		$display("comparisons %0d, mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	// sample 1 ns after the edge so its updates have landed
	task tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick

	task wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk_i);
		addr_i  <= ad;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] ad, output logic [31:0] d);
		@(posedge clk_i);
		addr_i <= ad;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd

	task t_reset;
		chk({28'h0, slip_en, warn, fault, coast}, 32'h8);
		rd(MPM_ADDR_THERM, a);
		chk(a, {16'h0000, MPM_COOL_RST});
		rd(MPM_ADDR_THERM2, a);
		chk(a, {8'h00, MPM_TC_RST, MPM_DUTY_RST});
		rd(8'h40, a);
		chk(a, 32'h0);
		rd(MPM_ADDR_OCNT, a);
		chk(a, 32'h0);
	endtask : t_reset

	// 200 % current at nominal frequency aims at four times full scale
	task t_thermal;
		set_freq <= 16'h03e8;
		set_load <= 16'h07d0;
		wr(MPM_ADDR_THERM2, {8'h00, MPM_TC_MIN, MPM_DUTY_RST});
		wr(MPM_ADDR_CTRL, 32'h4);
		tick(100 * TL - 4);
		chk(warn, 1'b0);
		rd(MPM_ADDR_TSTATE, a);
		chk(a > 32'h9000 && a < 32'ha800, 1'b1);
		for (i = 0; i < 200 * TL && warn !== 1'b1; i++) tick(1);
		chk(warn, 1'b1);
		rd(MPM_ADDR_TSTATE, a);
		chk(a >= MPM_TH_TRIP, 1'b1);
		set_load <= 16'h0000;
		// reads one tick apart: exactly one filter step toward zero
		rd(MPM_ADDR_TSTATE, a);
		tick(TL - 2);
		rd(MPM_ADDR_TSTATE, b);
		chk(a - b, a / (MPM_TICKS_PER_MIN * MPM_TC_MIN));
		set_run <= 1'b0;
		rd(MPM_ADDR_TSTATE, a);
		tick(TL - 2);
		rd(MPM_ADDR_TSTATE, b);
		chk(a - b, a / (MPM_TICKS_PER_MIN * MPM_TC_MIN * MPM_STOP_TC_MUL));
		set_run <= 1'b1;
		wr(MPM_ADDR_CTRL, 32'h0);
	endtask : t_thermal

	task t_speed;
		set_freq <= 16'h01f4;
		wr(MPM_ADDR_SPD, 32'h0002_0032);
		wr(MPM_ADDR_CTRL, {30'h0, MPM_RESP_WARN});
		set_slip <= 16'h0064;
		tick(50);
		chk(warn, 1'b0);
		for (i = 0; i < 400 && warn !== 1'b1; i++) tick(1);
		chk({slip_en, warn}, 2'b01);
		rd(MPM_ADDR_STATUS, a);
		chk(a, 32'h19);
		set_slip <= 16'h0000;
		tick(10);
		chk({slip_en, warn}, 2'b00);
		wr(MPM_ADDR_SPD, 32'h0000_0032);
		wr(MPM_ADDR_CTRL, 32'h0);
		tick(2);
		chk(slip_en, 1'b1);
		set_slip <= 16'hff9c;
		tick(20);
		chk({slip_en, warn, fault, coast}, 4'h0);
		set_slip <= 16'h0000;
		wr(MPM_ADDR_SPD, 32'h0000_0032);
		wr(MPM_ADDR_CTRL, {30'h0, MPM_RESP_FAULT});
		set_slip <= 16'hff9c;
		for (i = 0; i < 20 && coast !== 1'b1; i++) tick(1);
		chk({warn, fault, coast}, 3'b011);
		set_slip <= 16'h0000;
		wr(MPM_ADDR_CTRL, 32'h0);
		wr(MPM_ADDR_SPD, 32'h0000_0032);
	endtask : t_speed

	// 155 % sits midway between 105 % and the 205 % full-step level
	task t_ovl;
		set_freq <= 16'h03e8;
		for (int s = 1; s < 4; s++)
		begin
			set_load <= 16'h060e;
			wr(MPM_ADDR_OVL, {16'h03e8, 12'h802, (s == 3) ? MPM_RESP_FAULT : MPM_RESP_WARN, s[1:0]});
			rd(MPM_ADDR_OCNT, a);
			tick(TL - 2);
			rd(MPM_ADDR_OCNT, b);
			chk(b - a, 32'd500);
			for (i = 0; i < 25 * TL && {warn, fault} === 2'b00; i++) tick(1);
			rd(MPM_ADDR_OCNT, a);
			chk({warn, fault, a > MPM_OVL_TRIP}, (s == 3) ? 3'b011 : 3'b101);
			set_load <= 16'h0226;
			rd(MPM_ADDR_OCNT, a);
			tick(TL - 2);
			rd(MPM_ADDR_OCNT, b);
			chk(a - b, 32'd500);
			tick(25 * TL);
			rd(MPM_ADDR_OCNT, a);
			chk(a, 32'h0);
		end
		set_load <= 16'h060e;
		wr(MPM_ADDR_OVL, {16'h03e8, 12'h802, MPM_RESP_WARN, MPM_OVL_OFF});
		tick(2 * TL);
		rd(MPM_ADDR_OCNT, a);
		chk(a, 32'h0);
		set_load <= 16'h0000;
	endtask : t_ovl

	task t_ntc;
		set_hot <= 1'b1;
		wr(MPM_ADDR_CTRL, 32'h0);
		tick(5);
		chk({warn, fault, coast}, 3'b000);
		// writes are refused while the clock enable is low
		ce_i <= 1'b0;
		wr(MPM_ADDR_CTRL, 32'h10);
		tick(5);
		chk(warn, 1'b0);
		ce_i <= 1'b1;
		wr(MPM_ADDR_CTRL, 32'h10);
		tick(5);
		chk(warn, 1'b1);
		ce_i <= 1'b0;
		set_hot <= 1'b0;
		tick(5);
		chk(warn, 1'b1);
		ce_i <= 1'b1;
		set_hot <= 1'b1;
		wr(MPM_ADDR_CTRL, 32'h30);
		tick(5);
		chk({fault, coast}, 2'b11);
		set_hot <= 1'b0;
		wr(MPM_ADDR_CTRL, 32'h0);
	endtask : t_ntc

	initial
	begin
		fails = 0;
		comparisons = 0;
		resetn_i = 1'b0;
		ce_i = 1'b1;
		addr_i = 8'h00;
		wdata_i = 32'h0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		set_freq = 16'h0000;
		set_slip = 16'h0000;
		set_load = 16'h0000;
		set_run = 1'b1;
		set_hot = 1'b0;
		repeat (3) @(posedge clk_i);
		resetn_i <= 1'b1;
		tick(1);
		t_reset;
		t_thermal;
		t_speed;
		t_ovl;
		t_ntc;
		close_out;
	end

	// normal run is near 33k cycles, so over twice that means a hang
	initial
	begin
		repeat (80000) @(posedge clk_i);
		fails++;
		$display("mismatch at %0t: watchdog expired", $time);
		close_out;
	end
endmodule : motor_protection_monitor_tb
`default_nettype wire
